// ===== include/ptf_cfg.svh
// Register offsets, field positions and reset values for the tessellation front end
`ifndef PTF_CFG_SVH
`define PTF_CFG_SVH

// Register byte offsets
`define PTF_OFS_CTRL        12'h000
`define PTF_OFS_MAXLVL      12'h004
`define PTF_OFS_STATUS      12'h008
`define PTF_OFS_PATCHES     12'h00C
`define PTF_OFS_DROPS       12'h010

// Control register fields
`define PTF_CTRL_HAS_CTRL   0
`define PTF_CTRL_HAS_EVAL   1
`define PTF_CTRL_ORIGIN_LL  2

// Status register fields
`define PTF_STAT_ACTIVE     0
`define PTF_STAT_BUSY       1

// Reset values
`define PTF_CTRL_RST        3'h0
`define PTF_MAXLVL_RST      8'h40

// Level constants, Q8.8
`define PTF_LVL_ONE         16'h0100
`define PTF_LVL_TWO         16'h0200

`endif

// ===== include/ptf_pkg.sv
// Types shared by the tessellation front end files
package ptf_pkg;

    typedef enum logic [1:0] {
        PRIM_TRI,
        PRIM_RECT,
        PRIM_LINES
    } ptf_prim_t;

    typedef enum logic [1:0] {
        UNIFORM_SPACING_MODE,
        EVEN_FRACTIONAL_SPACING_MODE,
        ODD_FRACTIONAL_SPACING_MODE
    } ptf_spacing_t;

    // One patch from the control-shading stage; levels are signed Q8.8
    typedef struct packed {
        logic [31:0]       payload;
        logic [3:0][15:0]  outer_subdivision_level;
        logic [1:0][15:0]  inner_subdivision_level;
        logic [3:0]        outer_nan;
        ptf_prim_t         prim;
        ptf_spacing_t      spacing;
        logic              point_output_select_ctrl;
        logic              point_output_select_eval;
    } ptf_patch_t;

    // Quantised level: count, clamped level, end segment length, denominator
    typedef struct packed {
        logic [7:0]  cnt;
        logic [15:0] flvl;
        logic [15:0] ext;
        logic [15:0] den;
        logic        unif;
    } ptf_quant_t;

    // One vertex to the evaluation stage; position is num/den per axis
    typedef struct packed {
        logic [31:0] payload;
        logic [15:0] pos_u;
        logic [15:0] pos_v;
        logic [15:0] pos_w;
        logic [15:0] den_u;
        logic [15:0] den_v;
        ptf_prim_t   prim;
        logic        point;
        logic        interior;
        logic        origin_ll;
        logic        bypass;
        logic        last;
    } ptf_vtx_t;

endpackage

// ===== hdl/ptf_level_quant.sv
// Clamp and round one subdivision level for the selected spacing
`timescale 1ns/1ps
`default_nettype none
`include "ptf_cfg.svh"

module ptf_level_quant
    import ptf_pkg::*;
(
    input  wire logic [15:0] level,
    input  wire ptf_spacing_t spacing,
    input  wire logic [7:0]  max_level,
    output var  ptf_quant_t  result
);

    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] f;
    logic [7:0]  c;

    // Clamp, round up, then derive the end segment length
    always_comb
    begin
        lo = (spacing == EVEN_FRACTIONAL_SPACING_MODE) ? `PTF_LVL_TWO : `PTF_LVL_ONE;
        // odd upper bound max minus one
        hi = {max_level - ((spacing == ODD_FRACTIONAL_SPACING_MODE) ? 8'h01 : 8'h00), 8'h00};
        if (level[15] || level < lo)
            f = lo;
        else if (level > hi)
            f = hi;
        else
            f = level;
        c = f[15:8] + {7'h00, |f[7:0]};
        if (spacing == EVEN_FRACTIONAL_SPACING_MODE && c[0])
            c = c + 8'h01;
        if (spacing == ODD_FRACTIONAL_SPACING_MODE && !c[0])
            c = c + 8'h01;
        result.cnt  = c;
        result.flvl = f;
        result.unif = (spacing == UNIFORM_SPACING_MODE);
        // end segment (f - (n-2))/2 rounded up, so never zero length
        result.ext  = (f - {c - 8'h02, 8'h00} + 16'h0001) >> 1;
        // uniform edge spans n equal units
        result.den  = result.unif ? {c, 8'h00} : f;
    end

endmodule
`default_nettype wire

// ===== hdl/ptf_front_end.sv
// Tessellation front end: patch discard, level quantising, vertex emission
`timescale 1ns/1ps
`default_nettype none
`include "ptf_cfg.svh"

module ptf_front_end
    import ptf_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire ptf_patch_t  in_patch,
    output logic             out_valid,
    input  wire logic        out_ready,
    output var  ptf_vtx_t    out_vtx
);

    typedef enum logic [1:0] {S_IDLE, S_QUANT, S_EMIT} ptf_state_t;

    ptf_state_t   st_q;
    logic [2:0]   ctrl_q;
    logic [7:0]   maxlvl_q;
    logic [15:0]  patch_cnt_q;
    logic [15:0]  drop_cnt_q;
    logic [31:0]  prdata_q;
    logic         pready_q;
    logic         pslverr_q;
    logic         in_ready_q;
    logic         out_valid_q;
    ptf_vtx_t     out_q;
    ptf_patch_t   pat_q;
    ptf_quant_t   qu_q;
    ptf_quant_t   qv_q;
    logic [7:0]   i_q;
    logic [7:0]   j_q;

    logic         setup;
    logic         hit;
    logic         wr;
    logic [31:0]  rd_mux;
    logic         tess_on;
    logic         accept;
    logic         drop;
    logic         adv;
    logic [7:0]   imax;
    logic [7:0]   jmax;
    logic         last_v;
    ptf_vtx_t     vtx;
    logic [1:0][15:0]    lvl_sel;
    ptf_spacing_t [1:0]  sp_sel;
    ptf_quant_t   [1:0]  qres;

    // Position of boundary k on an edge, as a numerator over the edge denominator
    // symmetric end segments
    function automatic logic [15:0] pos_of(input logic [7:0] k, input ptf_quant_t q);
        if (k == 8'h00)
            pos_of = 16'h0000;
        else if (k == q.cnt)
            pos_of = q.den;
        else if (q.unif)
            pos_of = {k, 8'h00};
        else
            pos_of = q.ext + {k - 8'h01, 8'h00};
    endfunction

    // Outputs straight from flops
    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign in_ready  = in_ready_q;
    assign out_valid = out_valid_q;
    assign out_vtx   = out_q;

    // Bus decode; no wait state, read data registered in the setup cycle
    assign setup = psel && !penable;
    assign wr    = psel && penable && pready_q && pwrite && !pslverr_q;

    always_comb
    begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `PTF_OFS_CTRL:    rd_mux = {29'h0000_0000, ctrl_q};
            `PTF_OFS_MAXLVL:  rd_mux = {24'h00_0000, maxlvl_q};
            `PTF_OFS_STATUS:  rd_mux = {30'h0000_0000, st_q != S_IDLE, tess_on};
            `PTF_OFS_PATCHES: rd_mux = {16'h0000, patch_cnt_q};
            `PTF_OFS_DROPS:   rd_mux = {16'h0000, drop_cnt_q};
            default:          hit = 1'b0;
        endcase
    end

    // Bus answer registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup && !hit;
            if (setup)
                prdata_q <= (pwrite || !hit) ? 32'h0000_0000 : rd_mux;
        end
    end

    // Software control: stage presence, origin and level limit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q   <= `PTF_CTRL_RST;
            maxlvl_q <= `PTF_MAXLVL_RST;
        end
        else if (wr && paddr == `PTF_OFS_CTRL)
            ctrl_q <= pwdata[2:0];
        else if (wr && paddr == `PTF_OFS_MAXLVL)
            maxlvl_q <= pwdata[7:0];
    end

    // enabled only with both stages present
    assign tess_on = ctrl_q[`PTF_CTRL_HAS_CTRL] && ctrl_q[`PTF_CTRL_HAS_EVAL];
    assign accept  = in_valid && in_ready_q;
    assign adv     = !out_valid_q || out_ready;

    // discard on non-positive relevant outer level
    always_comb
    begin
        drop = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            if ((k < 2 || (k < 3 && in_patch.prim != PRIM_LINES) || in_patch.prim == PRIM_RECT)
                && (in_patch.outer_subdivision_level[k][15]
                    || in_patch.outer_subdivision_level[k] == 16'h0000
                    || in_patch.outer_nan[k]))
                drop = 1'b1;
        end
    end

    // Level routing: rect uses both inners, tri one, lines the outers
    always_comb
    begin
        lvl_sel[0] = pat_q.inner_subdivision_level[0];
        lvl_sel[1] = pat_q.inner_subdivision_level[1];
        sp_sel[0]  = pat_q.spacing;
        sp_sel[1]  = pat_q.spacing;
        if (pat_q.prim == PRIM_LINES)
        begin
            lvl_sel[0] = pat_q.outer_subdivision_level[1];
            lvl_sel[1] = pat_q.outer_subdivision_level[0];
            sp_sel[1]  = UNIFORM_SPACING_MODE;
        end
    end

    // One quantiser per domain axis
    for (genvar g = 0; g < 2; g++)
    begin : g_quant
        ptf_level_quant u_quant (
            .level     (lvl_sel[g]),
            .spacing   (sp_sel[g]),
            .max_level (maxlvl_q),
            .result    (qres[g])
        );
    end

    // Walk limits; triangle rows shrink as v grows
    assign imax   = (pat_q.prim == PRIM_TRI) ? qu_q.cnt - j_q : qu_q.cnt;
    assign jmax   = (pat_q.prim == PRIM_TRI) ? qu_q.cnt :
                    (pat_q.prim == PRIM_LINES) ? qv_q.cnt - 8'h01 : qv_q.cnt;
    assign last_v = (i_q == imax) && (j_q == jmax);

    // Vertex builder
    always_comb
    begin
        vtx         = '0;
        vtx.payload = pat_q.payload;
        vtx.prim    = pat_q.prim;
        vtx.pos_u   = pos_of(i_q, qu_q);
        vtx.den_u   = qu_q.den;
        // point output only when a stage selects it
        vtx.point   = pat_q.point_output_select_ctrl || pat_q.point_output_select_eval;
        // origin choice travels with the vertex
        vtx.origin_ll = ctrl_q[`PTF_CTRL_ORIGIN_LL];
        vtx.last    = last_v;
        if (pat_q.prim == PRIM_TRI)
        begin
            // barycentric sum equals the shared denominator
            vtx.pos_v = pos_of(j_q, qu_q);
            vtx.den_v = qu_q.den;
            vtx.pos_w = qu_q.den - vtx.pos_u - vtx.pos_v;
        end
        else
        begin
            // one strip per v step, u runs zero to one
            vtx.pos_v = pos_of(j_q, qv_q);
            vtx.den_v = qv_q.den;
            if (ctrl_q[`PTF_CTRL_ORIGIN_LL])
                vtx.pos_v = qv_q.den - vtx.pos_v;
        end
        // every rect and tri vertex flagged interior, isoline vertices never
        vtx.interior = (pat_q.prim != PRIM_LINES);
    end

    // Patch sequencing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_q <= S_IDLE;
        else
        begin
            unique case (st_q)
                S_IDLE:
                    if (accept && tess_on && !drop)
                        st_q <= S_QUANT;
                S_QUANT:
                    st_q <= S_EMIT;
                S_EMIT:
                    if (adv && last_v)
                        st_q <= S_IDLE;
            endcase
        end
    end

    // Patch capture, quantised levels and walk counters
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pat_q <= '0;
            qu_q  <= '0;
            qv_q  <= '0;
            i_q   <= 8'h00;
            j_q   <= 8'h00;
        end
        else if (accept)
            pat_q <= in_patch;
        else if (st_q == S_QUANT)
        begin
            // quantised counts and end segments held per patch
            qu_q <= qres[0];
            qv_q <= qres[1];
            i_q  <= 8'h00;
            j_q  <= 8'h00;
        end
        else if (st_q == S_EMIT && adv)
        begin
            if (i_q == imax)
            begin
                i_q <= 8'h00;
                j_q <= j_q + 8'h01;
            end
            else
                i_q <= i_q + 8'h01;
        end
    end

    // next patch admitted only once idle and output slot frees
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            in_ready_q <= 1'b0;
        else
            in_ready_q <= (st_q == S_IDLE) && !accept && adv;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_valid_q <= 1'b0;
            out_q       <= '0;
        end
        else if (accept && !tess_on)
        begin
            out_valid_q   <= 1'b1;
            out_q         <= '0;
            out_q.payload <= in_patch.payload;
            out_q.prim    <= in_patch.prim;
            out_q.bypass  <= 1'b1;
            out_q.last    <= 1'b1;
        end
        else if (st_q == S_EMIT && adv)
        begin
            out_valid_q <= 1'b1;
            out_q       <= vtx;
        end
        else if (out_ready)
            out_valid_q <= 1'b0;
    end

    // Activity counters, wrap silently
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            patch_cnt_q <= 16'h0000;
            drop_cnt_q  <= 16'h0000;
        end
        else if (accept)
        begin
            patch_cnt_q <= patch_cnt_q + 16'h0001;
            if (tess_on && drop)
                drop_cnt_q <= drop_cnt_q + 16'h0001;
        end
    end

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_tess_take;
        accept && tess_on && !drop;
    endsequence

    sequence s_quant_then_emit;
        st_q == S_QUANT ##1 st_q == S_EMIT;
    endsequence

    a_tess_entry: assert property (s_tess_take |=> s_quant_then_emit)
        else $error("tessellated patch did not enter quantise then emit");

    a_bypass_fwd: assert property (accept && !tess_on |=> out_valid_q && out_q.bypass
        && out_q.payload == $past(in_patch.payload))
        else $error("bypass primitive not forwarded unchanged");

    a_drop_silent: assert property (accept && tess_on && drop |=> !out_valid_q
        && st_q == S_IDLE && drop_cnt_q == $past(drop_cnt_q) + 16'h0001)
        else $error("discarded patch produced output");

    a_nan_drop: assert property (accept && tess_on && in_patch.outer_nan[0]
        |=> st_q == S_IDLE)
        else $error("NaN level patch not discarded");

    a_inner_keep: assert property (s_tess_take ##0 in_patch.inner_subdivision_level[0][15]
        |=> st_q == S_QUANT)
        else $error("negative inner level discarded patch");

    a_uniform_cnt: assert property (st_q == S_EMIT && qu_q.unif
        |-> qu_q.cnt >= 8'h01 && qu_q.cnt <= maxlvl_q)
        else $error("uniform count out of range");

    a_even_cnt: assert property (st_q == S_EMIT
        && pat_q.spacing == EVEN_FRACTIONAL_SPACING_MODE |-> !qu_q.cnt[0])
        else $error("even spacing produced odd count");

    a_odd_cnt: assert property (st_q == S_EMIT
        && pat_q.spacing == ODD_FRACTIONAL_SPACING_MODE |-> qu_q.cnt[0])
        else $error("odd spacing produced even count");

    // end segment never above one unit
    a_ext_len: assert property (st_q == S_EMIT && !qu_q.unif && qu_q.cnt > 8'h01
        |-> qu_q.ext <= `PTF_LVL_ONE && qu_q.ext != 16'h0000)
        else $error("fractional end segment out of range");

    a_pos_range: assert property (out_valid_q && !out_q.bypass |-> out_q.pos_u <= out_q.den_u
        && out_q.pos_v <= out_q.den_v && (out_q.prim != PRIM_TRI
        || (out_q.pos_w <= out_q.den_u
        && out_q.pos_u + out_q.pos_v + out_q.pos_w == out_q.den_u)))
        else $error("domain position outside range");

    // no intake while a patch is in flight
    a_patch_order: assert property (st_q != S_IDLE |-> !in_ready_q)
        else $error("input accepted mid-patch");

    a_out_hold: assert property (out_valid_q && !out_ready
        |=> out_valid_q && $stable(out_q))
        else $error("output changed while stalled");

endmodule
`default_nettype wire

// ===== tb/ptf_eval_sink.sv
// Evaluation-stage model: takes vertices, optionally stalls
`timescale 1ns/1ps
`default_nettype none

module ptf_eval_sink
    import ptf_pkg::*;
(
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire logic     stall_en,
    input  wire logic     out_valid,
    output logic          out_ready,
    input  wire ptf_vtx_t out_vtx,
    output logic          hold_err
);
    logic [1:0] ph_q;
    logic       wait_q;
    ptf_vtx_t   held_q;

    // ready one cycle in four when stalling
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ph_q      <= 2'h0;
            out_ready <= 1'b0;
        end
        else
        begin
            ph_q      <= ph_q + 2'h1;
            out_ready <= !stall_en || (ph_q == 2'h3);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_q   <= 1'b0;
            held_q   <= '0;
            hold_err <= 1'b0;
        end
        else
        begin
            wait_q <= out_valid && !out_ready;
            held_q <= out_vtx;
            if (wait_q && (!out_valid || out_vtx != held_q))
                hold_err <= 1'b1; // Sticky so the bench sees it late
        end
    end
endmodule
`default_nettype wire

// ===== tb/ptf_front_end_tb.sv
// Self-checking bench for the tessellation front end
`timescale 1ns/1ps
`default_nettype none
`include "ptf_cfg.svh"

module ptf_front_end_tb
    import ptf_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        in_valid, in_ready, out_valid, out_ready, stall_en, hold_err;
    ptf_patch_t  in_patch, q;
    ptf_vtx_t    out_vtx;
    ptf_vtx_t    got[$];
    int          err_total, comparisons, npat, maxl;
    ptf_spacing_t sps[5] = '{UNIFORM_SPACING_MODE, EVEN_FRACTIONAL_SPACING_MODE,
        ODD_FRACTIONAL_SPACING_MODE, UNIFORM_SPACING_MODE, ODD_FRACTIONAL_SPACING_MODE};
    logic [15:0] i0s[5] = '{16'h0280, 16'h0280, 16'h0200, 16'h1400, 16'h1400};
    logic [15:0] i1s[5] = '{16'h0100, 16'h0080, 16'hFF00, 16'h0100, 16'h0000};
    ptf_prim_t   dpr[6] = '{PRIM_RECT, PRIM_RECT, PRIM_TRI, PRIM_LINES, PRIM_LINES, PRIM_TRI};
    int          dix[6] = '{3, 3, 3, 2, 1, 2};
    logic [15:0] dlv[6] = '{16'h0000, 16'h0100, 16'h0000, 16'h0000, 16'hFF00, 16'h0000};
    int          dcn[6] = '{0, 0, 3, 2, 0, 0};

    ptf_front_end i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .in_valid, .in_ready, .in_patch, .out_valid, .out_ready, .out_vtx);
    ptf_eval_sink i_sink (.pclk, .presetn, .stall_en, .out_valid, .out_ready, .out_vtx,
        .hold_err);

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Falling edge sampling, handshake lines settled there
    always @(negedge pclk)
        if (out_valid === 1'b1 && out_ready === 1'b1)
            got.push_back(out_vtx);

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One APB transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int t;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do
        begin
            @(posedge pclk);
            t++;
        end
        while (pready !== 1'b1 && t < 100);
        // Answer taken at the very edge that samples pready high
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1)
        begin
            err_total++;
            $display("ERROR apb_ready expected 1 seen timeout");
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic send(input ptf_patch_t p);
        int t;
        @(posedge pclk);
        in_patch <= p;
        in_valid <= 1'b1;
        t = 0;
        do
        begin
            @(posedge pclk);
            t++;
        end
        while (in_ready !== 1'b1 && t < 1000);
        if (in_ready !== 1'b1)
        begin
            err_total++;
            $display("ERROR in_ready expected 1 seen timeout");
        end
        in_valid <= 1'b0;
        npat++;
    endtask

    task automatic run(input ptf_patch_t p, input int cnt);
        int t;
        got.delete();
        send(p);
        t = 0;
        @(negedge pclk);
        while ((got.size() < cnt || in_ready !== 1'b1) && t < 3000)
        begin
            @(negedge pclk);
            t++;
        end
        repeat (4) @(negedge pclk);
        chk("count", got.size(), cnt);
        if (cnt > 0)
            chk("last", got[cnt-1].last, 1);
    endtask

    // Expected clamp and rounding of one level, Q8.8
    task automatic quant(input logic [15:0] l, input ptf_spacing_t sp, output int n, output int f);
        int lo, hi;
        lo = (sp == EVEN_FRACTIONAL_SPACING_MODE) ? 512 : 256;
        hi = (sp == ODD_FRACTIONAL_SPACING_MODE) ? maxl * 256 - 256 : maxl * 256;
        f = $signed(l);
        f = (f < lo) ? lo : (f > hi) ? hi : f;
        n = (f + 255) / 256;
        if (sp != UNIFORM_SPACING_MODE && (n % 2 == (sp == EVEN_FRACTIONAL_SPACING_MODE)))
            n++;
    endtask

    function automatic int pos(int k, int n, int f, ptf_spacing_t sp);
        if (sp == UNIFORM_SPACING_MODE)
            return k * 256;
        if (k == 0)
            return 0;
        if (k == n)
            return f;
        return (f - (n - 2) * 256 + 1) / 2 + (k - 1) * 256;
    endfunction

    function automatic ptf_patch_t mk(ptf_prim_t pr, ptf_spacing_t sp, logic [15:0] i0,
        logic [15:0] i1);
        ptf_patch_t p;
        p = '0;
        p.payload = 32'hC0DE0000 + npat;
        p.outer_subdivision_level = {4{16'h0100}};
        p.inner_subdivision_level = {i1, i0};
        p.prim = pr;
        p.spacing = sp;
        return p;
    endfunction

    task automatic rect_chk(input ptf_patch_t p);
        int nu, nv, fu, fv, k;
        quant(p.inner_subdivision_level[0], p.spacing, nu, fu);
        quant(p.inner_subdivision_level[1], p.spacing, nv, fv);
        run(p, (nu + 1) * (nv + 1));
        k = 0;
        for (int j = 0; j <= nv; j++)
            for (int i = 0; i <= nu; i++)
            begin
                chk("pos_u", got[k].pos_u, pos(i, nu, fu, p.spacing));
                chk("den_u", got[k].den_u, pos(nu, nu, fu, p.spacing));
                chk("pos_v", got[k].pos_v, pos(j, nv, fv, p.spacing));
                chk("point", got[k].point, p.point_output_select_ctrl
                    | p.point_output_select_eval);
                chk("interior", got[k].interior, 1);
                chk("payload", got[k].payload, p.payload);
                k++;
            end
    endtask

    initial
    begin
        {presetn, psel, penable, pwrite, in_valid, stall_en} = '0;
        {paddr, pwdata, in_patch, err_total, comparisons, npat} = '0;
        maxl = 8;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `PTF_OFS_MAXLVL, 32'h0);
        chk("maxlvl", rd, 32'h40);
        apb(1'b0, 12'h0FC, 32'h0);
        chk("unmapped", {rd[30:0], er}, 32'h1);
        apb(1'b1, `PTF_OFS_MAXLVL, 32'h8);
        apb(1'b1, `PTF_OFS_CTRL, 32'h1);
        apb(1'b0, `PTF_OFS_STATUS, 32'h0);
        chk("active", rd[0], 0);
        q = mk(PRIM_RECT, UNIFORM_SPACING_MODE, 16'h0300, 16'h0300);
        run(q, 1);
        chk("bypass", {got[0].bypass, got[0].payload}, {1'b1, q.payload});
        $display("Test registers and bypass done");
        apb(1'b1, `PTF_OFS_CTRL, 32'h3);
        apb(1'b0, `PTF_OFS_STATUS, 32'h0);
        chk("active", rd[0], 1);
        // one prim and spacing field serves both stages
        for (int d = 0; d < 6; d++)
        begin
            q = mk(dpr[d], UNIFORM_SPACING_MODE, 16'hFF00, 16'hFF00);
            q.outer_subdivision_level[dix[d]] = dlv[d];
            q.outer_nan[dix[d]] = (d == 1);
            run(q, dcn[d]);
        end
        apb(1'b0, `PTF_OFS_DROPS, 32'h0);
        chk("drops", rd, 4);
        $display("Test discard done");
        for (int d = 0; d < 5; d++)
        begin
            q = mk(PRIM_RECT, sps[d], i0s[d], i1s[d]);
            {q.point_output_select_eval, q.point_output_select_ctrl} = d[1:0];
            rect_chk(q);
        end
        $display("Test spacing done");
        run(mk(PRIM_TRI, UNIFORM_SPACING_MODE, 16'h0300, 16'h0000), 10);
        foreach (got[k])
            chk("bary", got[k].pos_u + got[k].pos_v + got[k].pos_w, 32'h0000_0300);
        q = mk(PRIM_LINES, EVEN_FRACTIONAL_SPACING_MODE, 16'h0000, 16'h0000);
        q.outer_subdivision_level[0] = 16'h0200;
        q.outer_subdivision_level[1] = 16'h0280;
        run(q, 10);
        foreach (got[k])
        begin
            chk("line_u", got[k].pos_u, pos(k % 5, 4, 640, q.spacing));
            chk("line_v", got[k].pos_v, (k / 5) * 256);
            chk("line_den", got[k].den_v, 32'h0000_0200);
        end
        $display("Test triangles and lines done");
        apb(1'b1, `PTF_OFS_CTRL, 32'h7);
        run(mk(PRIM_RECT, UNIFORM_SPACING_MODE, 16'h0100, 16'h0100), 4);
        chk("origin", {got[0].origin_ll, got[0].pos_v}, {1'b1, 16'h0100});
        apb(1'b1, `PTF_OFS_CTRL, 32'h3);
        stall_en <= 1'b1;
        rect_chk(mk(PRIM_RECT, ODD_FRACTIONAL_SPACING_MODE, 16'h0300, 16'h0200));
        chk("hold", hold_err, 0);
        apb(1'b0, `PTF_OFS_PATCHES, 32'h0);
        chk("patches", rd, npat);
        $display("Test stall and origin done");
        finish_test();
    end

    initial
    begin
        repeat (30000) @(posedge pclk);
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
